// *** osc_map.svh ***
`ifndef OSC_MAP_SVH
`define OSC_MAP_SVH

// Register byte offsets, one aligned word each
`define OSC_OFF_CFG 8'h00
`define OSC_OFF_LOOP 8'h04
`define OSC_OFF_EXLF 8'h08
`define OSC_OFF_XTAL 8'h0c
`define OSC_OFF_MCLK 8'h10
`define OSC_OFF_STAT 8'h14

// Oscillator configuration fields
`define OSC_CFG_STOPOFF 0
`define OSC_CFG_OFF 1
`define OSC_CFG_FRQ_LO 2
`define OSC_CFG_FRQ_HI 3
// Correction loop control fields
`define OSC_LOOP_FCL 0
`define OSC_LOOP_EXRES 1
// External slow clock and crystal fields
`define OSC_EXLF_SEL 0
`define OSC_XTAL_SEL 0
`define OSC_XTAL_START 1
// Main clock configuration field
`define OSC_MCLK_USELF 0
// Status fields
`define OSC_ST_LFGOOD 0
`define OSC_ST_MCLKLF 1
`define OSC_ST_SYSON 2
`define OSC_ST_EXLF 3
`define OSC_ST_FRQ_LO 4
`define OSC_ST_FRQ_HI 5
`define OSC_ST_FCL 6
`define OSC_ST_MONPIN 7
`define OSC_ST_PINOK 8

// Mid-frequency divider per oscillator setting (keeps 4 MHz)
`define OSC_DIV_24 4'h6
`define OSC_DIV_4 4'h1
`define OSC_DIV_16 4'h4
`define OSC_DIV_32 4'h8

// Timing: clock rate and times in their own units
`define OSC_MCLK_MHZ 20
`define OSC_LF_SETTLE_NS 1000
`define OSC_LF_SETTLE_CYC ((`OSC_LF_SETTLE_NS*`OSC_MCLK_MHZ+999)/1000)
`define OSC_GF_GAP_NS 100
`define OSC_GF_GAP_CYC ((`OSC_GF_GAP_NS*`OSC_MCLK_MHZ+999)/1000)
`define OSC_PIN_WIN_NS 100000
`define OSC_PIN_WIN_CYC ((`OSC_PIN_WIN_NS*`OSC_MCLK_MHZ)/1000)
`define OSC_PIN_EDGES 3'h3

`endif

// *** osc_pkg.sv ***
package osc_pkg;

   // Power mode reported by the system controller
   typedef enum logic [2:0] {
      OSC_PM_RUN = 3'h0,
      OSC_PM_SLEEP = 3'h1,
      OSC_PM_STOP = 3'h3,
      OSC_PM_STANDBY = 3'h2,
      OSC_PM_SHUTDOWN = 3'h6
   } osc_pmode_type;

   // System oscillator frequency settings
   typedef enum logic [1:0] {
      OSC_F24 = 2'h0,
      OSC_F4 = 2'h1,
      OSC_F16 = 2'h2,
      OSC_F32 = 2'h3
   } osc_freq_type;

   // Slow clock source
   typedef enum logic [1:0] {
      OSC_SRC_LOW_FREQ_OSC = 2'h0,
      OSC_SRC_XTAL = 2'h1,
      OSC_SRC_PIN = 2'h2
   } osc_src_type;

   // Glitch-free mux sequence, Gray along the loop
   typedef enum logic [1:0] {
      OSC_GF_A = 2'h0,
      OSC_GF_AB = 2'h1,
      OSC_GF_B = 2'h3,
      OSC_GF_BA = 2'h2
   } osc_gf_st_type;

   typedef struct packed {
      osc_gf_st_type st;
      logic [3:0] gap;
      logic en_a;
      logic en_b;
   } osc_gf_type;

   typedef struct packed {
      logic stopoff;
      logic dis;
      osc_freq_type freq_req;
      osc_freq_type freq_cur;
      logic frequency_correction_loop;
      logic exres;
      logic exlf;
      logic xtal_sel;
      logic xtal_start;
      logic use_lf;
      logic lf_good;
      logic [7:0] lf_cnt;
      logic [2:0] pin_edges;
      logic [11:0] pin_win;
      logic pin_ok;
      logic lfr_s1;
      logic lfr_s2;
      logic pin_s1;
      logic pin_s2;
      logic pin_s3;
      logic ph_s1;
      logic ph_s2;
      logic ph_s3;
      logic ap_wr;
      logic [7:0] ap_addr;
      logic [31:0] hrdata;
      logic sys_en;
      logic [3:0] mid_div;
      logic low_freq_osc_en;
      logic mon_pin;
      osc_src_type src;
   } osc_ctl_type;

endpackage

// *** osc_gfmux.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "osc_map.svh"

module osc_gfmux (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Selection: 0 takes source a, 1 takes source b
   input wire logic sel_i,
   // Per-source gate enables
   output logic en_a_o,
   output logic en_b_o
);
   import osc_pkg::*;

   osc_gf_type s_q;
   osc_gf_type s_d;

   // Break before make: the old gate closes, a dead gap passes,
   // then the new gate opens, so no runt pulse can reach the tree
   always_comb begin
      s_d = s_q;
      case (s_q.st)
         OSC_GF_A: begin
            if (sel_i) begin
               s_d.en_a = 1'b0;
               s_d.gap = 4'h0;
               s_d.st = OSC_GF_AB;
            end
         end
         OSC_GF_AB: begin
            s_d.gap = s_q.gap + 4'h1;
            if (s_q.gap == 4'(`OSC_GF_GAP_CYC - 1)) begin
               s_d.en_b = 1'b1;
               s_d.st = OSC_GF_B;
            end
         end
         OSC_GF_B: begin
            if (!sel_i) begin
               s_d.en_b = 1'b0;
               s_d.gap = 4'h0;
               s_d.st = OSC_GF_BA;
            end
         end
         OSC_GF_BA: begin
            s_d.gap = s_q.gap + 4'h1;
            if (s_q.gap == 4'(`OSC_GF_GAP_CYC - 1)) begin
               s_d.en_a = 1'b1;
               s_d.st = OSC_GF_A;
            end
         end
         default: begin
            s_d.st = OSC_GF_A;
            s_d.en_a = 1'b1;
            s_d.en_b = 1'b0;
         end
      endcase
   end

   // State register; source a owns the tree after reset
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_q <= '{st: OSC_GF_A, gap: 4'h0, en_a: 1'b1, en_b: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign en_a_o = s_q.en_a;
   assign en_b_o = s_q.en_b;

endmodule
`default_nettype wire

// *** osc_ctrl.sv ***
// Contract
// - Boot reset: slow oscillator runs, feeds slow clock
// - Startup monitor sets slow oscillator ready flag
// - Brownout reset: system oscillator 24 MHz, main clock
// - Mid-frequency divider keeps 4 MHz output
// - Frequency changes applied phase aligned
// - Correction enable cannot be cleared by software
// - Stop-off bit: oscillator off, slow clock in stop
// - Leaving stop restores oscillator and main clock
// - Manual off bit: slow clock in all modes
// - Oscillator always off in standby and shutdown
// - Monitor checks pin when crystal not started
// - Pin selection locked until boot reset
// - Main clock through glitch-free mux
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "osc_map.svh"

module osc_ctrl (
   // Clock and resets
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic sys_rst_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Power mode from the system controller
   input wire osc_pkg::osc_pmode_type pmode_i,
   // Asynchronous oscillator and pin inputs
   input wire logic lf_ready_i,
   input wire logic slow_clk_pin_i,
   input wire logic sys_phase_i,
   // Oscillator controls
   output logic sys_en_o,
   output var osc_pkg::osc_freq_type sys_freq_o,
   output logic [3:0] mid_div_o,
   output logic fcl_en_o,
   output logic ext_res_o,
   output logic low_freq_osc_en_o,
   output var osc_pkg::osc_src_type slow_src_o,
   output logic mon_pin_o,
   // Main clock gates
   output logic mclk_sys_en_o,
   output logic mclk_lf_en_o
);
   import osc_pkg::*;

   osc_ctl_type s_q;
   osc_ctl_type s_d;
   logic want_lf;
   logic gf_sys;
   logic gf_lf;
   logic ap_take;
   logic ph_edge;
   logic pin_edge;
   logic in_stop;
   logic deep;

   // Divider for each oscillator setting
   function automatic logic [3:0] div_of(input osc_freq_type f);
      case (f)
         OSC_F24: div_of = `OSC_DIV_24;
         OSC_F4: div_of = `OSC_DIV_4;
         OSC_F16: div_of = `OSC_DIV_16;
         OSC_F32: div_of = `OSC_DIV_32;
         default: div_of = `OSC_DIV_24;
      endcase
   endfunction

   // Reads assemble each register from a given state image
   function automatic logic [31:0] rd_word(input logic [7:0] a,
                                           input osc_ctl_type s,
                                           input logic mlf);
      logic [31:0] w;
      w = 32'h0;
      case (a)
         `OSC_OFF_CFG: begin
            w[`OSC_CFG_STOPOFF] = s.stopoff;
            w[`OSC_CFG_OFF] = s.dis;
            w[`OSC_CFG_FRQ_HI:`OSC_CFG_FRQ_LO] = s.freq_req;
         end
         `OSC_OFF_LOOP: begin
            w[`OSC_LOOP_FCL] = s.frequency_correction_loop;
            w[`OSC_LOOP_EXRES] = s.exres;
         end
         `OSC_OFF_EXLF: w[`OSC_EXLF_SEL] = s.exlf;
         `OSC_OFF_XTAL: begin
            w[`OSC_XTAL_SEL] = s.xtal_sel;
            w[`OSC_XTAL_START] = s.xtal_start;
         end
         `OSC_OFF_MCLK: w[`OSC_MCLK_USELF] = s.use_lf;
         `OSC_OFF_STAT: begin
            w[`OSC_ST_LFGOOD] = s.lf_good;
            w[`OSC_ST_MCLKLF] = mlf;
            w[`OSC_ST_SYSON] = s.sys_en;
            w[`OSC_ST_EXLF] = (s.src == OSC_SRC_PIN);
            w[`OSC_ST_FRQ_HI:`OSC_ST_FRQ_LO] = s.freq_cur;
            w[`OSC_ST_FCL] = s.frequency_correction_loop;
            w[`OSC_ST_MONPIN] = !s.xtal_start;
            w[`OSC_ST_PINOK] = s.pin_ok;
         end
         default: w = 32'h0; // Unmapped reads as zero, still OKAY
      endcase
      rd_word = w;
   endfunction

   // Main clock handover between oscillator and slow clock
   osc_gfmux u_gfmux (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .sel_i(want_lf),
      .en_a_o(gf_sys),
      .en_b_o(gf_lf)
   );

   // Mode decode and synchronised edges (read only from second stage)
   assign in_stop = (pmode_i == OSC_PM_STOP);
   assign deep = (pmode_i == OSC_PM_STANDBY) ||
                 (pmode_i == OSC_PM_SHUTDOWN);
   assign ph_edge = s_q.ph_s2 && !s_q.ph_s3;
   assign pin_edge = s_q.pin_s2 && !s_q.pin_s3;
   assign ap_take = hsel_i && hready_i && htrans_i[1];

   // Slow clock feeds the main clock when software asks, the oscillator
   // is off by hand, or the low power mode forbids the oscillator
   assign want_lf = s_q.use_lf || s_q.dis ||
                    (in_stop && s_q.stopoff) ||
                    deep;

   always_comb begin
      s_d = s_q;

      // Two-stage synchronisers for every asynchronous input
      s_d.lfr_s1 = lf_ready_i;
      s_d.lfr_s2 = s_q.lfr_s1;
      s_d.pin_s1 = slow_clk_pin_i;
      s_d.pin_s2 = s_q.pin_s1;
      s_d.pin_s3 = s_q.pin_s2;
      s_d.ph_s1 = sys_phase_i;
      s_d.ph_s2 = s_q.ph_s1;
      s_d.ph_s3 = s_q.ph_s2;

      // Startup monitor: ready must hold for the settle time; once good
      // the flag stays until boot reset, dropouts are ignored
      if (s_q.lfr_s2 && !s_q.lf_good) begin
         s_d.lf_cnt = s_q.lf_cnt + 8'h1;
         if (s_q.lf_cnt == 8'(`OSC_LF_SETTLE_CYC - 1)) begin
            s_d.lf_good = 1'b1;
         end
      end else if (!s_q.lfr_s2) begin
         s_d.lf_cnt = 8'h0;
      end

      // Pin monitor counts edges per window while the crystal is idle
      if (!s_q.xtal_start) begin
         if (s_q.pin_win == 12'(`OSC_PIN_WIN_CYC - 1)) begin
            s_d.pin_win = 12'h0;
            s_d.pin_ok = (s_q.pin_edges >= `OSC_PIN_EDGES);
            s_d.pin_edges = 3'h0;
         end else begin
            s_d.pin_win = s_q.pin_win + 12'h1;
            if (pin_edge && s_q.pin_edges != 3'h7) begin
               s_d.pin_edges = s_q.pin_edges + 3'h1;
            end
         end
      end else begin
         s_d.pin_win = 12'h0;
         s_d.pin_edges = 3'h0;
         s_d.pin_ok = 1'b0;
      end

      // Data phase of a pending write
      if (s_q.ap_wr) begin
         case (s_q.ap_addr)
            `OSC_OFF_CFG: begin
               s_d.stopoff = hwdata_i[`OSC_CFG_STOPOFF];
               s_d.dis = hwdata_i[`OSC_CFG_OFF];
               s_d.freq_req = osc_freq_type'(
                  hwdata_i[`OSC_CFG_FRQ_HI:`OSC_CFG_FRQ_LO]);
            end
            `OSC_OFF_LOOP: begin
               // Mode is frozen once the loop runs; clears are dropped
               if (!s_q.frequency_correction_loop) begin
                  s_d.frequency_correction_loop = hwdata_i[`OSC_LOOP_FCL];
                  s_d.exres = hwdata_i[`OSC_LOOP_EXRES];
               end
            end
            `OSC_OFF_EXLF: begin
               // Set only; a zero write cannot undo the pin choice
               if (hwdata_i[`OSC_EXLF_SEL]) begin
                  s_d.exlf = 1'b1;
               end
            end
            `OSC_OFF_XTAL: begin
               s_d.xtal_sel = hwdata_i[`OSC_XTAL_SEL];
               s_d.xtal_start = hwdata_i[`OSC_XTAL_START];
            end
            `OSC_OFF_MCLK: s_d.use_lf = hwdata_i[`OSC_MCLK_USELF];
            default: s_d.ap_wr = 1'b0; // Unmapped write is dropped
         endcase
      end

      // Slow clock source; pin selection outranks all else for good
      if (s_d.exlf) begin
         s_d.src = OSC_SRC_PIN;
      end else if (s_d.xtal_sel) begin
         s_d.src = OSC_SRC_XTAL;
      end else begin
         s_d.src = OSC_SRC_LOW_FREQ_OSC;
      end
      s_d.low_freq_osc_en = (s_d.src == OSC_SRC_LOW_FREQ_OSC);

      // Oscillator enable follows mode every cycle, so leaving stop
      // brings it back without software help
      s_d.sys_en = !s_q.dis &&
                   !(in_stop && s_q.stopoff) &&
                   !deep;

      // Frequency and divider move together on a phase edge of the
      // oscillator; while it is off there is nobody to disturb
      if (s_q.freq_req != s_q.freq_cur) begin
         if (ph_edge || !s_q.sys_en) begin
            s_d.freq_cur = s_q.freq_req;
            s_d.mid_div = div_of(s_q.freq_req);
         end
      end

      // Address phase: note writes, answer reads from the updated image
      s_d.ap_wr = 1'b0;
      if (ap_take) begin
         s_d.ap_wr = hwrite_i;
         s_d.ap_addr = haddr_i[7:0];
         if (haddr_i[31:8] != 24'h0 || hsize_i != 3'h2) begin
            s_d.ap_addr = 8'hff; // Outside the map or not a word
         end
         if (!hwrite_i) begin
            s_d.hrdata = rd_word(s_d.ap_addr, s_d, gf_lf);
         end
      end

      // System reset clears ordinary settings but not sticky ones
      if (sys_rst_i) begin
         s_d.stopoff = 1'b0;
         s_d.dis = 1'b0;
         s_d.freq_req = OSC_F24;
         s_d.use_lf = 1'b0;
         s_d.xtal_sel = 1'b0;
         s_d.xtal_start = 1'b0;
         s_d.ap_wr = 1'b0;
      end

      // Monitor watches the pin while the crystal is not started;
      // registered so the output pin sees no decode glitch
      s_d.mon_pin = !s_d.xtal_start;
   end

   // Boot reset: slow oscillator up, system oscillator at 24 MHz
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.freq_req <= OSC_F24;
         s_q.freq_cur <= OSC_F24;
         s_q.mid_div <= `OSC_DIV_24;
         s_q.sys_en <= 1'b1;
         s_q.low_freq_osc_en <= 1'b1;
         s_q.mon_pin <= 1'b1;
         s_q.src <= OSC_SRC_LOW_FREQ_OSC;
         s_q.ap_addr <= 8'hff;
      end else begin
         s_q <= s_d;
      end
   end

   // Register outputs; the gates come from the mux flops
   assign hrdata_o = s_q.hrdata;
   assign hreadyout_o = 1'b1; // Zero wait states, constant OKAY
   assign hresp_o = 1'b0;
   assign sys_en_o = s_q.sys_en;
   assign sys_freq_o = s_q.freq_cur;
   assign mid_div_o = s_q.mid_div;
   assign fcl_en_o = s_q.frequency_correction_loop;
   assign ext_res_o = s_q.exres;
   assign low_freq_osc_en_o = s_q.low_freq_osc_en;
   assign slow_src_o = s_q.src;
   assign mon_pin_o = s_q.mon_pin;
   assign mclk_sys_en_o = gf_sys;
   assign mclk_lf_en_o = gf_lf;

endmodule
`default_nettype wire

// *** osc_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module osc_ctrl_chk (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Bus answer
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   // Mode and phase inputs
   input wire osc_pkg::osc_pmode_type pmode_i,
   input wire logic sys_phase_i,
   // Oscillator and gate outputs
   input wire logic sys_en_o,
   input wire osc_pkg::osc_freq_type sys_freq_o,
   input wire logic [3:0] mid_div_o,
   input wire logic fcl_en_o,
   input wire osc_pkg::osc_src_type slow_src_o,
   input wire logic mclk_sys_en_o,
   input wire logic mclk_lf_en_o
);
   import osc_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic [3:0] age_q, age_d, div_exp;

   // Cycles since the phase marker was high, saturating
   always_comb begin
      age_d = (age_q == 4'hf) ? age_q : age_q + 4'h1;
      if (sys_phase_i) begin
         age_d = 4'h0;
      end
   end
   always_ff @(posedge mclk_i) begin
      age_q <= rst_i ? 4'hf : age_d;
   end

   // Divider that keeps the mid clock at 4 MHz
   always_comb begin
      case (sys_freq_o)
         OSC_F4: div_exp = 4'h1;
         OSC_F16: div_exp = 4'h4;
         OSC_F32: div_exp = 4'h8;
         default: div_exp = 4'h6;
      endcase
   end

   sequence s_lf_off2;
      !mclk_lf_en_o [*2];
   endsequence
   sequence s_deep2;
      (pmode_i == OSC_PM_STANDBY || pmode_i == OSC_PM_SHUTDOWN) [*2];
   endsequence

   property p_excl;
      !(mclk_sys_en_o && mclk_lf_en_o);
   endproperty
   property p_gap;
      $fell(mclk_sys_en_o) |-> s_lf_off2;
   endproperty
   property p_div;
      $stable(sys_freq_o) [*2] |-> mid_div_o == div_exp;
   endproperty
   property p_fcl;
      fcl_en_o |=> fcl_en_o;
   endproperty
   property p_src;
      slow_src_o == OSC_SRC_PIN |=> slow_src_o == OSC_SRC_PIN;
   endproperty
   property p_deep;
      s_deep2 |-> ##[0:4] !sys_en_o;
   endproperty
   property p_freq;
      $changed(sys_freq_o) && $past(sys_en_o) |-> age_q < 4'h9;
   endproperty
   property p_bus;
      hreadyout_o && !hresp_o;
   endproperty

   a_excl: assert property (p_excl) else $error("both gates open");
   a_gap: assert property (p_gap) else $error("gate gap short");
   a_div: assert property (p_div) else $error("divider wrong");
   a_fcl: assert property (p_fcl) else $error("loop enable lost");
   a_src: assert property (p_src) else $error("pin source lost");
   a_deep: assert property (p_deep) else $error("osc on in deep");
   a_freq: assert property (p_freq) else $error("freq off phase");
   a_bus: assert property (p_bus) else $error("bus answer bad");
endmodule

bind osc_ctrl osc_ctrl_chk u_chk (
   .mclk_i(mclk_i), .rst_i(rst_i), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .pmode_i(pmode_i), .sys_phase_i(sys_phase_i),
   .sys_en_o(sys_en_o), .sys_freq_o(sys_freq_o), .mid_div_o(mid_div_o),
   .fcl_en_o(fcl_en_o), .slow_src_o(slow_src_o),
   .mclk_sys_en_o(mclk_sys_en_o), .mclk_lf_en_o(mclk_lf_en_o)
);
`default_nettype wire

// *** osc_pin_src.sv ***
`timescale 1ns/1ps
`default_nettype none

module osc_pin_src #(
   parameter int HALF_NS = 15259
) (
   // Run control
   input wire logic en_i,
   // Square wave to the slow clock pin
   output logic clk_o
);
   // Even duty square wave; held low when stopped, no free run
   initial begin
      clk_o = 1'b0;
      forever begin
         #(HALF_NS);
         clk_o = en_i ? ~clk_o : 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** tb_oscillator_source_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("mismatch %s expected %0h seen %0h", n, e, g); \
   end \
end

module tb_oscillator_source_control;
   import osc_pkg::*;
   logic clk, rst, srst, hsel, hwrite, lfr, ph, pin_en, pin;
   logic hrdy, hresp, sys_en, frequency_correction_loop, xres, lfen, mpin, gs, gl;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] mdiv;
   logic [3:0] dv [0:3] = '{4'h6, 4'h1, 4'h4, 4'h8};
   osc_pmode_type pmode;
   osc_freq_type freq;
   osc_src_type src;
   int failures, checks_done;

   osc_ctrl dut (
      .mclk_i(clk), .rst_i(rst), .sys_rst_i(srst), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
      .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
      .pmode_i(pmode), .lf_ready_i(lfr), .slow_clk_pin_i(pin),
      .sys_phase_i(ph), .sys_en_o(sys_en), .sys_freq_o(freq),
      .mid_div_o(mdiv), .fcl_en_o(frequency_correction_loop), .ext_res_o(xres),
      .low_freq_osc_en_o(lfen), .slow_src_o(src), .mon_pin_o(mpin),
      .mclk_sys_en_o(gs), .mclk_lf_en_o(gl)
   );
   // Faster than typical so the pin check window sees enough edges
   osc_pin_src #(.HALF_NS(10000)) u_src (.en_i(pin_en), .clk_o(pin));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Bounded wait for the slave's ready at a rising edge
   task automatic rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hrdy !== 1'b1 && n < 40);
      if (hrdy !== 1'b1) begin
         failures++;
         wrap_up();
      end
   endtask

   // One single word transfer; read data lands in rd
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      rdy();
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      rd = hrdata;
      hsel <= 1'b0;
   endtask

   // Poll a status bit until set, bounded
   task automatic poll(input int b);
      int n;
      n = 0;
      do begin
         bus(1'b0, 8'h14, 32'h0);
         n++;
      end while (rd[b] !== 1'b1 && n < 1500);
      if (rd[b] !== 1'b1) begin
         failures++;
         wrap_up();
      end
   endtask

   task automatic t_reset();
      `CHK("sys_en", 1'b1, sys_en)
      `CHK("sys_freq", OSC_F24, freq)
      `CHK("mid_div", 4'h6, mdiv)
      `CHK("low_freq_osc_en", 1'b1, lfen)
      `CHK("slow_src", OSC_SRC_LOW_FREQ_OSC, src)
      `CHK("gate_sys", 1'b1, gs)
      `CHK("gate_lf", 1'b0, gl)
      `CHK("mon_pin", 1'b1, mpin)
      bus(1'b0, 8'h14, 32'h0);
      `CHK("ready_flag", 1'b0, rd[0])
      lfr <= 1'b1;
      poll(0);
      $display("test reset done");
   endtask

   task automatic t_freq();
      osc_freq_type f, prev;
      prev = OSC_F24;
      for (int i = 1; i <= 4; i++) begin
         f = osc_freq_type'(i % 4);
         bus(1'b1, 8'h00, {28'h0, f, 2'h0});
         cyc(8);
         `CHK("hold_freq", prev, freq)
         ph <= 1'b1;
         cyc(4);
         ph <= 1'b0;
         cyc(8);
         `CHK("sys_freq", f, freq)
         `CHK("mid_div", dv[i % 4], mdiv)
         prev = f;
      end
      $display("test freq done");
   endtask

   task automatic t_stop();
      bus(1'b1, 8'h00, 32'h1);
      pmode <= OSC_PM_STOP;
      cyc(8);
      `CHK("sys_en", 1'b0, sys_en)
      `CHK("gate_lf", 1'b1, gl)
      pmode <= OSC_PM_RUN;
      cyc(8);
      `CHK("sys_en", 1'b1, sys_en)
      `CHK("gate_sys", 1'b1, gs)
      bus(1'b1, 8'h00, 32'h2);
      pmode <= OSC_PM_SLEEP;
      cyc(8);
      `CHK("sys_en", 1'b0, sys_en)
      `CHK("gate_lf", 1'b1, gl)
      pmode <= OSC_PM_RUN;
      bus(1'b1, 8'h00, 32'h0);
      pmode <= OSC_PM_STANDBY;
      cyc(8);
      `CHK("sys_en", 1'b0, sys_en)
      pmode <= OSC_PM_SHUTDOWN;
      cyc(8);
      `CHK("sys_en", 1'b0, sys_en)
      pmode <= OSC_PM_RUN;
      cyc(8);
      `CHK("gate_sys", 1'b1, gs)
      bus(1'b0, 8'h20, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      `CHK("hresp", 1'b0, hresp)
      $display("test stop done");
   endtask

   task automatic t_fcl();
      bus(1'b1, 8'h04, 32'h1);
      cyc(4);
      `CHK("fcl_en", 1'b1, frequency_correction_loop)
      `CHK("ext_res", 1'b0, xres)
      bus(1'b1, 8'h04, 32'h0);
      cyc(4);
      `CHK("fcl_en", 1'b1, frequency_correction_loop)
      srst <= 1'b1;
      cyc(2);
      srst <= 1'b0;
      bus(1'b0, 8'h04, 32'h0);
      `CHK("loop_reg", 32'h1, rd)
      $display("test loop done");
   endtask

   task automatic t_pin();
      bus(1'b1, 8'h0c, 32'h3);
      cyc(2);
      `CHK("mon_pin", 1'b0, mpin)
      `CHK("slow_src", OSC_SRC_XTAL, src)
      `CHK("low_freq_osc_en", 1'b0, lfen)
      bus(1'b1, 8'h0c, 32'h0);
      cyc(2);
      `CHK("mon_pin", 1'b1, mpin)
      pin_en <= 1'b1;
      poll(8);
      bus(1'b1, 8'h08, 32'h1);
      cyc(8);
      `CHK("slow_src", OSC_SRC_PIN, src)
      bus(1'b1, 8'h08, 32'h0);
      cyc(8);
      `CHK("slow_src", OSC_SRC_PIN, src)
      bus(1'b1, 8'h10, 32'h1);
      cyc(8);
      `CHK("gate_lf", 1'b1, gl)
      bus(1'b1, 8'h10, 32'h0);
      cyc(8);
      `CHK("gate_sys", 1'b1, gs)
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(1);
      `CHK("slow_src", OSC_SRC_LOW_FREQ_OSC, src)
      `CHK("fcl_en", 1'b0, frequency_correction_loop)
      $display("test pin done");
   endtask

   // Hang guard at 100000 cycles
   initial begin
      #5000000;
      failures++;
      wrap_up();
   end

   initial begin
      rst = 1'b1;
      srst = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pmode = OSC_PM_RUN;
      lfr = 1'b0;
      ph = 1'b0;
      pin_en = 1'b0;
      failures = 0;
      checks_done = 0;
      cyc(20);
      rst <= 1'b0;
      cyc(1);
      t_reset();
      t_freq();
      t_stop();
      t_fcl();
      t_pin();
      wrap_up();
   end
endmodule
`default_nettype wire
